// ==== core/ccr_clock_source_top.sv ====
/*
  Clock source selection, PLL lock sequencing, wait/halt handling and reset cause
  flags, with an AHB-Lite register slave and one level interrupt.
  Assumes a single 50 MHz clock; instruction and watchdog strobes come from logic on
  that clock; the reset pin and auxiliary clock presence are asynchronous.
*/
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ccr_consts.svh"
`default_nettype none

// Contract
// - Wait while multiplier output is half-crystal over sixteen enters low power mode.
// - In wait, peripheral clock uses auxiliary clock if wait select set and present.
// - In run, peripheral clock uses auxiliary clock if run select set and present.
// - After waking from a wait that froze the PLL, wait lock delay before use.
// - Wait with low-power-on-wait clear stops processor, leaves peripheral clock unchanged.
// - PLL divider field value 6 divides PLL output by 7.
// - Prescaler value 7 makes processor clock the peripheral clock divided by 8.
// - Reset pin falling edge outside halt leaves both reset cause flags at zero.
// - Watchdog expiry reset sets watchdog flag and clears software flag.
// - Halt stops until external reset; with enable set, software flag then reads one.
// - Reset cause flags are read-only and updated by hardware at each reset.
// - PLL divider divides by field plus one; field 7 switches the PLL off.
// - Two-bit multiplier select picks factor 6, 8, 10 or 14.
// - Multiplier output is half-crystal, its sixteenth, or PLL product over divisor.
module ccr_clock_source_top
  import ccr_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        WAIT_INSTR,
  input  wire logic        HALT_INSTR,
  input  wire logic        WAKE_IRQ,
  input  wire logic        WDG_ZERO,
  input  wire logic        RESET_PIN_N,
  input  wire logic        AUX_CLK_PRESENT,
  output logic      [1:0]  PERIPH_CLK_SRC,
  output logic             PLL_ON,
  output logic             PLL_LOCKED,
  output logic      [3:0]  PLL_FACTOR,
  output logic      [2:0]  PLL_DIVISOR,
  output logic             PROC_CLK_RUN,
  output logic      [3:0]  PROC_DIVISOR,
  output logic             LOW_POWER,
  output logic             HALTED,
  output logic             CHIP_RESET,
  output logic             IRQ
);

  localparam logic [9:0] LOCK_LAST = 10'(`CCR_LOCK_CYCLES - 1);

  ccr_state_type r_reg;
  ccr_state_type r_next;
  logic          pin_fall;

  assign pin_fall = r_reg.rpin_prev & ~r_reg.rpin_s2;

  function automatic logic [3:0] pll_factor_of(input logic [1:0] sel);
    unique case (sel)
      2'h0: pll_factor_of = 4'h6;
      2'h1: pll_factor_of = 4'h8;
      2'h2: pll_factor_of = 4'ha;
      2'h3: pll_factor_of = 4'he;
    endcase
  endfunction : pll_factor_of

  always_comb
  begin
    logic [2:0]  set_ev;
    logic [2:0]  clr_ev;
    logic        aux_ok;
    logic        pll_on;
    logic        aux_req;
    ccr_src_type mult_src;
    set_ev = 3'h0;
    clr_ev = 3'h0;
    aux_ok = r_reg.aux_s2;
    pll_on = 1'b0;
    aux_req = 1'b0;
    mult_src = CCR_SRC_HALF;
    r_next = r_reg;
    r_next.chip_rst = 1'b0;
    r_next.aux_s1 = AUX_CLK_PRESENT;
    r_next.aux_s2 = r_reg.aux_s1;
    r_next.rpin_s1 = RESET_PIN_N;
    r_next.rpin_s2 = r_reg.rpin_s1;
    r_next.rpin_prev = r_reg.rpin_s2;

    // Data phase write; unmapped offsets, the flag register and the status register ignore writes
    if (r_reg.dph_valid && r_reg.dph_write)
    begin
      unique case (r_reg.dph_addr)
        `CCR_OFS_CLOCK_CONTROL:
        begin
          r_next.wait_aux_sel = HWDATA[`CCR_BIT_WAIT_AUX_SEL];
          r_next.run_aux_sel = HWDATA[`CCR_BIT_RUN_AUX_SEL];
          r_next.lp_on_wait = HWDATA[`CCR_BIT_LP_ON_WAIT];
          r_next.stop_rst_en = HWDATA[`CCR_BIT_STOP_RST_EN];
        end
        `CCR_OFS_SOURCE_SELECT:
        begin
          r_next.div16 = HWDATA[`CCR_BIT_DIV16];
          r_next.pll_sel = HWDATA[`CCR_BIT_PLL_SEL];
        end
        `CCR_OFS_PLL_CONFIG:
        begin
          r_next.pll_div = HWDATA[`CCR_POS_PLL_DIV +: 3];
          r_next.pll_mul = HWDATA[`CCR_POS_PLL_MUL +: 2];
        end
        `CCR_OFS_PRESCALER: r_next.presc = HWDATA[2:0];
        `CCR_OFS_IRQ_STATUS: clr_ev = HWDATA[2:0];
        `CCR_OFS_IRQ_MASK: r_next.irq_mask = HWDATA[2:0];
        default: ;
      endcase
    end
    r_next.dph_valid = HSEL & HTRANS[1] & HREADY & (HSIZE == 3'h2);
    r_next.dph_write = HWRITE;
    r_next.dph_addr = HADDR[7:0];

    pll_on = (r_next.pll_div != `CCR_PLL_OFF_CODE);
    unique case (r_reg.mode)
      CCR_RUN:
      begin
        if (HALT_INSTR)
          r_next.mode = CCR_HALT;
        else if (WAIT_INSTR)
        begin
          r_next.mode = CCR_WAIT;
          // Low power wait forces the sixteenth, so a selected PLL that is switched on is frozen
          if (r_next.lp_on_wait && r_next.pll_sel && pll_on && !r_next.div16)
            r_next.pll_frozen = 1'b1;
        end
      end
      CCR_WAIT:
      begin
        if (WAKE_IRQ)
        begin
          r_next.mode = CCR_RUN;
          set_ev[`CCR_IRQ_WAKE] = 1'b1;
          if (r_reg.pll_frozen)
          begin
            r_next.pll_frozen = 1'b0;
            r_next.locked = 1'b0;
            r_next.lock_cnt = 10'h000;
          end
        end
      end
      CCR_HALT: ;
    endcase

    // Lock timer restarts whenever the PLL is off; a frozen PLL keeps its count
    if (!pll_on)
    begin
      r_next.locked = 1'b0;
      r_next.lock_cnt = 10'h000;
      r_next.pll_frozen = 1'b0;
    end
    else if (!r_next.pll_frozen && !r_next.locked)
    begin
      if (r_next.lock_cnt == LOCK_LAST)
      begin
        r_next.locked = 1'b1;
        set_ev[`CCR_IRQ_LOCK] = 1'b1;
      end
      else
        r_next.lock_cnt = r_next.lock_cnt + 10'h001;
    end

    if (r_reg.periph_src == CCR_SRC_AUX && !aux_ok)
      set_ev[`CCR_IRQ_AUX_LOST] = 1'b1;

    // Chip resets restart the clock setup but keep the bus pipeline alive
    if (pin_fall || WDG_ZERO)
    begin
      r_next.sw_flag = pin_fall && r_reg.mode == CCR_HALT && r_reg.stop_rst_en;
      r_next.wdg_flag = !pin_fall;
      r_next.chip_rst = 1'b1;
      r_next.wait_aux_sel = 1'b0;
      r_next.run_aux_sel = 1'b0;
      r_next.lp_on_wait = 1'b0;
      r_next.stop_rst_en = 1'b0;
      r_next.div16 = 1'b0;
      r_next.pll_sel = 1'b0;
      r_next.pll_div = `CCR_RST_PLL_DIV;
      r_next.pll_mul = `CCR_RST_PLL_MUL;
      r_next.presc = `CCR_RST_PRESC;
      r_next.mode = CCR_RUN;
      r_next.pll_frozen = 1'b0;
      r_next.lock_cnt = 10'h000;
      r_next.locked = 1'b0;
      r_next.irq_mask = 3'h0;
      set_ev = 3'h0;
      clr_ev = 3'h7;
      pll_on = 1'b0;
    end

    if (r_next.div16 || (r_next.mode == CCR_WAIT && r_next.lp_on_wait))
      mult_src = CCR_SRC_DIV16;
    else if (r_next.pll_sel && pll_on && r_next.locked)
      mult_src = CCR_SRC_PLL;
    else
      mult_src = CCR_SRC_HALF;
    aux_req = (r_next.mode == CCR_WAIT) ? r_next.wait_aux_sel : r_next.run_aux_sel;
    r_next.periph_src = (aux_req && aux_ok) ? CCR_SRC_AUX : mult_src;
    r_next.low_power = (r_next.mode == CCR_WAIT) && (mult_src == CCR_SRC_DIV16);
    r_next.proc_run = (r_next.mode == CCR_RUN);
    r_next.proc_div = {1'b0, r_next.presc} + 4'h1;
    r_next.pll_on_o = pll_on;
    r_next.pll_divisor = pll_on ? r_next.pll_div + 3'h1 : 3'h0;
    r_next.pll_factor = pll_factor_of(r_next.pll_mul);

    // A hardware event in the clearing cycle survives the clear
    r_next.irq_stat = (r_reg.irq_stat & ~clr_ev) | set_ev;
    r_next.irq = |(r_next.irq_stat & r_next.irq_mask);

    // Read data taken from next values so a write just before a read is seen
    r_next.rdata = 32'h0000_0000;
    if (r_next.dph_valid && !HWRITE)
    begin
      unique case (HADDR[7:0])
        `CCR_OFS_CLOCK_CONTROL:
          r_next.rdata[3:0] = {r_next.stop_rst_en, r_next.lp_on_wait,
                               r_next.run_aux_sel, r_next.wait_aux_sel};
        `CCR_OFS_SOURCE_SELECT: r_next.rdata[1:0] = {r_next.pll_sel, r_next.div16};
        `CCR_OFS_PLL_CONFIG:
        begin
          r_next.rdata[`CCR_POS_PLL_DIV +: 3] = r_next.pll_div;
          r_next.rdata[`CCR_POS_PLL_MUL +: 2] = r_next.pll_mul;
        end
        `CCR_OFS_PRESCALER: r_next.rdata[2:0] = r_next.presc;
        `CCR_OFS_RESET_FLAGS: r_next.rdata[1:0] = {r_next.wdg_flag, r_next.sw_flag};
        `CCR_OFS_STATUS:
          r_next.rdata[5:0] = {r_next.periph_src, r_next.mode == CCR_HALT,
                               aux_ok, r_next.locked, r_next.low_power};
        `CCR_OFS_IRQ_STATUS: r_next.rdata[2:0] = r_next.irq_stat;
        `CCR_OFS_IRQ_MASK: r_next.rdata[2:0] = r_next.irq_mask;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      r_reg <= '0;
      r_reg.pll_div <= `CCR_RST_PLL_DIV;
      r_reg.rpin_s1 <= 1'b1;
      r_reg.rpin_s2 <= 1'b1;
      r_reg.rpin_prev <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  assign HRDATA = r_reg.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign PERIPH_CLK_SRC = r_reg.periph_src;
  assign PLL_ON = r_reg.pll_on_o;
  assign PLL_LOCKED = r_reg.locked;
  assign PLL_FACTOR = r_reg.pll_factor;
  assign PLL_DIVISOR = r_reg.pll_divisor;
  assign PROC_CLK_RUN = r_reg.proc_run;
  assign PROC_DIVISOR = r_reg.proc_div;
  assign LOW_POWER = r_reg.low_power;
  assign HALTED = (r_reg.mode == CCR_HALT);
  assign CHIP_RESET = r_reg.chip_rst;
  assign IRQ = r_reg.irq;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_low_power_src: assert property (r_reg.low_power |->
    r_reg.mode == CCR_WAIT && r_reg.periph_src inside {CCR_SRC_DIV16, CCR_SRC_AUX})
    else $error("low power without divided clock");
  a_wait_aux_use: assert property ((r_reg.mode == CCR_WAIT && r_reg.wait_aux_sel
    && $past(r_reg.aux_s2)) |-> r_reg.periph_src == CCR_SRC_AUX)
    else $error("wait auxiliary clock not used");
  a_run_aux_use: assert property ((r_reg.mode == CCR_RUN && r_reg.run_aux_sel
    && $past(r_reg.aux_s2)) |-> r_reg.periph_src == CCR_SRC_AUX)
    else $error("run auxiliary clock not used");
  a_aux_absent: assert property ((r_reg.periph_src == CCR_SRC_AUX) |-> $past(r_reg.aux_s2))
    else $error("absent auxiliary clock selected");
  a_lock_delay: assert property ($rose(r_reg.locked) |-> $past(r_reg.lock_cnt) == LOCK_LAST)
    else $error("lock without full delay");
  a_wake_relock: assert property ((r_reg.mode == CCR_WAIT && r_reg.pll_frozen && WAKE_IRQ
    && !pin_fall && !WDG_ZERO) |=> !r_reg.locked [*8])
    else $error("frozen pll used right after wake");
  a_wait_proc_stop: assert property ((r_reg.mode == CCR_WAIT && !r_reg.lp_on_wait
    && r_reg.div16 && !r_reg.wait_aux_sel) |->
    !r_reg.proc_run && r_reg.periph_src == CCR_SRC_DIV16)
    else $error("wait disturbed peripheral clock");
  a_pll_div_six: assert property (r_reg.pll_div == 3'h6 |-> r_reg.pll_divisor == 3'h7)
    else $error("divider six not seven");
  a_pll_off: assert property (r_reg.pll_div == 3'h7 |-> !r_reg.pll_on_o && !r_reg.locked)
    else $error("pll on with off code");
  a_presc_eight: assert property (r_reg.presc == 3'h7 |-> r_reg.proc_div == 4'h8)
    else $error("prescaler seven not eight");
  a_pin_flags: assert property ((pin_fall && r_reg.mode != CCR_HALT) |=>
    !r_reg.sw_flag && !r_reg.wdg_flag && r_reg.chip_rst)
    else $error("pin reset flags wrong");
  a_wdg_flags: assert property ((WDG_ZERO && !pin_fall) |=> r_reg.wdg_flag && !r_reg.sw_flag)
    else $error("watchdog reset flags wrong");
  a_halt_flags: assert property ((r_reg.mode == CCR_HALT && pin_fall && r_reg.stop_rst_en)
    |=> r_reg.sw_flag && !r_reg.wdg_flag && r_reg.mode == CCR_RUN)
    else $error("halt reset flags wrong");
  a_flags_hold: assert property ((!pin_fall && !WDG_ZERO) |=>
    $stable(r_reg.sw_flag) && $stable(r_reg.wdg_flag))
    else $error("flags changed without reset");
  a_factor_max: assert property (r_reg.pll_mul == 2'h3 |-> r_reg.pll_factor == 4'he)
    else $error("factor select three not fourteen");
  a_pll_src: assert property (r_reg.periph_src == CCR_SRC_PLL |->
    r_reg.locked && r_reg.pll_on_o && !r_reg.div16)
    else $error("pll source while unusable");
  a_low_power_entry: assert property ((r_reg.mode == CCR_RUN && WAIT_INSTR && !HALT_INSTR
    && r_reg.div16 && !r_reg.dph_valid && !pin_fall && !WDG_ZERO) |=> r_reg.low_power)
    else $error("wait on sixteenth without low power");
  a_halt_held: assert property ((r_reg.mode == CCR_HALT && !pin_fall && !WDG_ZERO) |=>
    r_reg.mode == CCR_HALT)
    else $error("halt left without reset");
  a_chip_rst_cfg: assert property ((pin_fall || WDG_ZERO) |=> r_reg.mode == CCR_RUN
    && r_reg.pll_div == 3'h7 && r_reg.irq_stat == 3'h0)
    else $error("chip reset left state behind");

  c_low_power_wait: cover property (r_reg.mode == CCR_WAIT && r_reg.low_power);
  c_relock_wake: cover property (r_reg.pll_frozen ##1 !r_reg.pll_frozen ##[1:600] r_reg.locked);
  c_halt_reset: cover property (r_reg.mode == CCR_HALT ##[1:50] r_reg.sw_flag);
  c_aux_clock: cover property (r_reg.periph_src == CCR_SRC_AUX);

endmodule : ccr_clock_source_top

`default_nettype wire

// ==== core/ccr_consts.svh ====
/*
  Offsets, field positions, reset values and timing counts of the clock source
  and reset cause block. Assumes a 50 MHz system clock and byte addresses on AHB-Lite.
*/
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

`define CCR_OFS_CLOCK_CONTROL   8'h00
`define CCR_OFS_SOURCE_SELECT   8'h04
`define CCR_OFS_PLL_CONFIG      8'h08
`define CCR_OFS_PRESCALER       8'h0c
`define CCR_OFS_RESET_FLAGS     8'h10
`define CCR_OFS_STATUS          8'h14
`define CCR_OFS_IRQ_STATUS      8'h18
`define CCR_OFS_IRQ_MASK        8'h1c

`define CCR_BIT_WAIT_AUX_SEL    0
`define CCR_BIT_RUN_AUX_SEL     1
`define CCR_BIT_LP_ON_WAIT      2
`define CCR_BIT_STOP_RST_EN     3
`define CCR_BIT_DIV16           0
`define CCR_BIT_PLL_SEL         1
`define CCR_POS_PLL_DIV         0
`define CCR_POS_PLL_MUL         4
`define CCR_BIT_SW_FLAG         0
`define CCR_BIT_WDG_FLAG        1
`define CCR_IRQ_LOCK            0
`define CCR_IRQ_WAKE            1
`define CCR_IRQ_AUX_LOST        2

`define CCR_RST_PLL_DIV         3'h7
`define CCR_RST_PLL_MUL         2'h0
`define CCR_RST_PRESC           3'h0
`define CCR_PLL_OFF_CODE        3'h7

`define CCR_PLL_LOCK_NS         10000
`define CCR_CLK_PERIOD_NS       20
`define CCR_LOCK_CYCLES  ((`CCR_PLL_LOCK_NS + `CCR_CLK_PERIOD_NS - 1) / `CCR_CLK_PERIOD_NS)

`endif

// ==== core/ccr_pkg.sv ====
/*
  Types of the clock source and reset cause block.
  Assumes ccr_consts.svh on the include path.
*/
`default_nettype none
package ccr_pkg;

  typedef enum logic [1:0] {CCR_RUN, CCR_WAIT, CCR_HALT} ccr_mode_type;
  typedef enum logic [1:0] {CCR_SRC_HALF, CCR_SRC_DIV16, CCR_SRC_PLL, CCR_SRC_AUX} ccr_src_type;

  typedef struct packed {
    logic         wait_aux_sel;
    logic         run_aux_sel;
    logic         lp_on_wait;
    logic         stop_rst_en;
    logic         div16;
    logic         pll_sel;
    logic [2:0]   pll_div;
    logic [1:0]   pll_mul;
    logic [2:0]   presc;
    logic         sw_flag;
    logic         wdg_flag;
    ccr_mode_type mode;
    logic         pll_frozen;
    logic [9:0]   lock_cnt;
    logic         locked;
    logic [2:0]   irq_stat;
    logic [2:0]   irq_mask;
    logic         dph_valid;
    logic         dph_write;
    logic [7:0]   dph_addr;
    logic [31:0]  rdata;
    ccr_src_type  periph_src;
    logic [3:0]   pll_factor;
    logic [2:0]   pll_divisor;
    logic         pll_on_o;
    logic         proc_run;
    logic [3:0]   proc_div;
    logic         low_power;
    logic         chip_rst;
    logic         irq;
    logic         aux_s1;
    logic         aux_s2;
    logic         rpin_s1;
    logic         rpin_s2;
    logic         rpin_prev;
  } ccr_state_type;

endpackage : ccr_pkg

`default_nettype wire

// ==== bench/ccr_tb.sv ====
/*
  Self-checking bench for the clock source and reset cause block: AHB-Lite
  register tasks, instruction strobes, reset pin and auxiliary clock stimulus.
  Assumes ccr_pkg and ccr_consts.svh compiled first; 50 MHz system clock.
*/
`timescale 1ns/1ps
`include "ccr_consts.svh"
`default_nettype none
module tb;
  localparam logic [3:0] EV_WAIT = 4'h1;
  localparam logic [3:0] EV_HALT = 4'h2;
  localparam logic [3:0] EV_WAKE = 4'h4;
  localparam logic [3:0] EV_WDG  = 4'h8;
  logic        clk_sys;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [3:0]  ev;
  logic        rpin_n;
  logic        aux;
  logic [1:0]  src;
  logic        pll_on;
  logic        locked;
  logic [3:0]  factor;
  logic [2:0]  divisor;
  logic        proc_run;
  logic [3:0]  proc_div;
  logic        low_power;
  logic        halted;
  logic        chip_rst;
  logic        irq;
  int          err_count;
  int          cmp_count;
  int          pulses;
  int          n;
  logic [31:0] d;
  logic [3:0]  fac_tab [4] = '{4'h6, 4'h8, 4'ha, 4'he};

  ccr_clock_source_top dut (
    .CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .WAIT_INSTR(ev[0]), .HALT_INSTR(ev[1]),
    .WAKE_IRQ(ev[2]), .WDG_ZERO(ev[3]), .RESET_PIN_N(rpin_n), .AUX_CLK_PRESENT(aux),
    .PERIPH_CLK_SRC(src), .PLL_ON(pll_on), .PLL_LOCKED(locked), .PLL_FACTOR(factor),
    .PLL_DIVISOR(divisor), .PROC_CLK_RUN(proc_run), .PROC_DIVISOR(proc_div),
    .LOW_POWER(low_power), .HALTED(halted), .CHIP_RESET(chip_rst), .IRQ(irq)
  );

  always #10 clk_sys = ~clk_sys;

  // Counted on the falling edge so the registered pulse is settled
  always @(negedge clk_sys)
  begin
    if (chip_rst === 1'b1)
      pulses++;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic settle(input int k);
    repeat (k) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  // Ready is sampled on the falling edge, half a cycle before each rising edge, so a late answer is waited for
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int   k;
    logic r;
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    k = 0;
    do
    begin
      @(negedge clk_sys);
      r = hready;
      @(posedge clk_sys);
      k++;
    end while (r !== 1'b1 && k < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    k = 0;
    do
    begin
      @(negedge clk_sys);
      r = hready;
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
      @(posedge clk_sys);
      k++;
    end while (r !== 1'b1 && k < 50);
    chk("hready", 32'h1, {31'h0, r});
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, exp, x);
  endtask : rdchk

  task automatic strobe(input logic [3:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 4'h0;
    settle(2);
  endtask : strobe

  task automatic set_aux(input logic v);
    @(posedge clk_sys);
    aux <= v;
    settle(5);
  endtask : set_aux

  task automatic pin_reset;
    pulses = 0;
    @(posedge clk_sys);
    rpin_n <= 1'b0;
    settle(8);
    @(posedge clk_sys);
    rpin_n <= 1'b1;
    settle(4);
  endtask : pin_reset

  task automatic wait_lock;
    n = 0;
    while (locked !== 1'b1 && n < 700)
    begin
      @(negedge clk_sys);
      n++;
    end
  endtask : wait_lock

  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("Error watchdog expected end of tests seen timeout");
    report_and_stop();
  end

  initial
  begin
    clk_sys = 1'b0; rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hwdata = 32'h0; ev = 4'h0; rpin_n = 1'b1; aux = 1'b0;
    err_count = 0; cmp_count = 0; pulses = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    settle(2);
    chk("proc run", 32'h1, {31'h0, proc_run});
    chk("pll on", 32'h0, {31'h0, pll_on});
    rdchk("pll config", `CCR_OFS_PLL_CONFIG, 32'h7);
    rdchk("flags", `CCR_OFS_RESET_FLAGS, 32'h0);
    rdchk("unmapped", 8'h20, 32'h0);
    $display("Test reset done");

    for (int i = 0; i < 8; i++)
    begin
      wr(`CCR_OFS_PLL_CONFIG, {26'h0, i[1:0], 1'b0, i[2:0]});
      wr(`CCR_OFS_PRESCALER, {29'h0, i[2:0]});
      settle(2);
      chk("factor", {28'h0, fac_tab[i[1:0]]}, {28'h0, factor});
      chk("divisor", (i == 7) ? 32'h0 : 32'(i + 1), {29'h0, divisor});
      chk("pll on", (i == 7) ? 32'h0 : 32'h1, {31'h0, pll_on});
      chk("proc div", 32'(i + 1), {28'h0, proc_div});
    end
    $display("Test dividers done");

    wr(`CCR_OFS_SOURCE_SELECT, 32'h1);
    settle(2);
    chk("src div16", 32'h1, {30'h0, src});
    strobe(EV_WAIT);
    chk("proc stop", 32'h0, {31'h0, proc_run});
    chk("src kept", 32'h1, {30'h0, src});
    chk("low power", 32'h1, {31'h0, low_power});
    strobe(EV_WAKE);
    chk("proc back", 32'h1, {31'h0, proc_run});
    wr(`CCR_OFS_CLOCK_CONTROL, 32'h1);
    strobe(EV_WAIT);
    chk("wait aux absent", 32'h1, {30'h0, src});
    strobe(EV_WAKE);
    set_aux(1'b1);
    strobe(EV_WAIT);
    chk("wait aux", 32'h3, {30'h0, src});
    strobe(EV_WAKE);
    chk("run no aux sel", 32'h1, {30'h0, src});
    $display("Test wait done");

    wr(`CCR_OFS_IRQ_STATUS, 32'h7);
    wr(`CCR_OFS_IRQ_MASK, 32'h4);
    wr(`CCR_OFS_CLOCK_CONTROL, 32'h2);
    settle(2);
    chk("run aux", 32'h3, {30'h0, src});
    set_aux(1'b0);
    chk("aux lost src", 32'h1, {30'h0, src});
    chk("irq set", 32'h1, {31'h0, irq});
    wr(`CCR_OFS_IRQ_STATUS, 32'h4);
    settle(2);
    chk("irq clear", 32'h0, {31'h0, irq});
    wr(`CCR_OFS_IRQ_MASK, 32'h0);
    set_aux(1'b1);
    set_aux(1'b0);
    chk("irq masked", 32'h0, {31'h0, irq});
    rdchk("irq status", `CCR_OFS_IRQ_STATUS, 32'h4);
    wr(`CCR_OFS_IRQ_MASK, 32'h4);
    settle(2);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(`CCR_OFS_IRQ_STATUS, 32'h4);
    wr(`CCR_OFS_CLOCK_CONTROL, 32'h0);
    settle(2);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("Test aux done");

    wr(`CCR_OFS_PLL_CONFIG, 32'h0);
    wr(`CCR_OFS_SOURCE_SELECT, 32'h2);
    wait_lock();
    chk("lock time", 32'h1, {31'h0, n > 400 && n < 700});
    chk("src pll", 32'h2, {30'h0, src});
    rdchk("status pll", `CCR_OFS_STATUS, 32'h22);
    wr(`CCR_OFS_CLOCK_CONTROL, 32'h4);
    strobe(EV_WAIT);
    chk("lp wait", 32'h1, {31'h0, low_power});
    chk("lp wait src", 32'h1, {30'h0, src});
    strobe(EV_WAKE);
    chk("relock pending", 32'h0, {31'h0, locked});
    chk("pll unused", 32'h0, {31'h0, src == 2'h2});
    wait_lock();
    chk("relock time", 32'h1, {31'h0, n > 400 && n < 700});
    chk("src pll again", 32'h2, {30'h0, src});
    rdchk("irq events", `CCR_OFS_IRQ_STATUS, 32'h3);
    $display("Test lock done");

    pin_reset();
    chk("pin pulse", 32'h1, 32'(pulses));
    rdchk("flags pin", `CCR_OFS_RESET_FLAGS, 32'h0);
    strobe(EV_WDG);
    settle(2);
    rdchk("flags wdg", `CCR_OFS_RESET_FLAGS, 32'h2);
    wr(`CCR_OFS_RESET_FLAGS, 32'h1);
    rdchk("flags ro", `CCR_OFS_RESET_FLAGS, 32'h2);
    wr(`CCR_OFS_CLOCK_CONTROL, 32'h8);
    strobe(EV_HALT);
    chk("halted", 32'h1, {31'h0, halted});
    chk("halt proc", 32'h0, {31'h0, proc_run});
    strobe(EV_WAKE);
    chk("halt kept", 32'h1, {31'h0, halted});
    pin_reset();
    rdchk("flags halt", `CCR_OFS_RESET_FLAGS, 32'h1);
    chk("halt left", 32'h0, {31'h0, halted});
    pin_reset();
    rdchk("flags renew", `CCR_OFS_RESET_FLAGS, 32'h0);
    $display("Test reset cause done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
